//--- src/ssmc_top.sv
// Operation
// - supervisor full performance gives about 2 us mask
// - supervisor normal performance gives about 150 us mask
// - enabled normal-performance core supervisor selects slow wake
// - any core unit normal means slow wake
// - core units off or full: fast wake
// - supply normal unit switches off if configured
// - manual keep setting holds units in LPM
// - supply auto control idles monitor in LPM
// - overvoltage enable turns monitor into overvoltage reset
// - core event routes to reset or interrupt
`timescale 1ns/1ps
`default_nettype none

module ssmc_top
  import ssmc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // power mode request (0 active, 1..5 low-power mode)
  input wire logic [2:0] power_mode,
  // raw comparator events from the analog units
  input wire logic core_supervisor_trip,
  input wire logic core_monitor_trip,
  input wire logic supply_supervisor_trip,
  input wire logic supply_monitor_trip,
  // unit states to the analog side
  output logic [1:0] core_supervisor_state,
  output logic [1:0] core_monitor_state,
  output logic [1:0] supply_supervisor_state,
  output logic [1:0] supply_monitor_state,
  // wake-up path and event routing
  output logic slow_wake,
  output logic power_on_reset_req,
  output logic supervisor_irq
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------

  // state of one unit from its enable and full-performance bits
  function automatic ssmc_unit_state_t active_state(input logic en, input logic fp);
    if (!en)
      active_state = SSMC_OFF;
    else if (fp)
      active_state = SSMC_FULL;
    else
      active_state = SSMC_NORMAL;
  endfunction : active_state

  // state in low-power modes 2..4
  function automatic ssmc_unit_state_t lpm_state(input ssmc_unit_state_t am,
                                                 input logic keep, input logic auto_ctl);
    if (auto_ctl)
      lpm_state = (am == SSMC_FULL) ? SSMC_NORMAL : SSMC_OFF;
    else if (keep)
      lpm_state = am;
    else
      lpm_state = SSMC_OFF;
  endfunction : lpm_state

  // mask length for a side: full performance is short
  function automatic logic [MASK_CNT_W-1:0] mask_len(input logic fp);
    if (fp)
      mask_len = MASK_CNT_W'(FAST_MASK_CYCLES);
    else
      mask_len = MASK_CNT_W'(SLOW_MASK_CYCLES);
  endfunction : mask_len

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_reg; // release shift chain
  logic rst_n; // synchronised reset used everywhere else

  // two flops release reset cleanly on a clock edge
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  // ------------------------------------------------------------
  // control registers and settling masks
  // ------------------------------------------------------------
  logic [15:0] core_ctl_reg, core_ctl_next; // core-side control
  logic [15:0] supply_ctl_reg, supply_ctl_next; // supply-side control
  logic [MASK_CNT_W-1:0] core_cnt_reg, core_cnt_next; // core mask countdown
  logic [MASK_CNT_W-1:0] supply_cnt_reg, supply_cnt_next; // supply mask countdown
  logic core_dly_reg, core_dly_next; // core-side delay flag
  logic supply_dly_reg, supply_dly_next; // supply-side delay flag
  logic core_wr; // write to core control
  logic supply_wr; // write to supply control

  assign core_wr = reg_write && (reg_addr == CORE_CTL_ADDR);
  assign supply_wr = reg_write && (reg_addr == SUPPLY_CTL_ADDR);

  // next values: a write reloads the mask, which then counts down
  always_comb
  begin
    core_ctl_next = core_ctl_reg;
    supply_ctl_next = supply_ctl_reg;
    core_cnt_next = core_cnt_reg;
    supply_cnt_next = supply_cnt_reg;
    core_dly_next = core_dly_reg;
    supply_dly_next = supply_dly_reg;
    // core side
    if (core_wr)
    begin
      core_ctl_next = reg_wdata;
      core_cnt_next = mask_len(reg_wdata[SUP_FP_BIT]);
      core_dly_next = 1'b1;
    end
    else if (core_cnt_reg != '0)
    begin
      core_cnt_next = core_cnt_reg - 1'b1;
      // flag drops as the last mask cycle ends
      if (core_cnt_reg == MASK_CNT_W'(1))
        core_dly_next = 1'b0;
    end
    // supply side
    if (supply_wr)
    begin
      supply_ctl_next = reg_wdata;
      supply_cnt_next = mask_len(reg_wdata[SUP_FP_BIT]);
      supply_dly_next = 1'b1;
    end
    else if (supply_cnt_reg != '0)
    begin
      supply_cnt_next = supply_cnt_reg - 1'b1;
      if (supply_cnt_reg == MASK_CNT_W'(1))
        supply_dly_next = 1'b0;
    end
  end

  // masks are armed after reset too, so no false event comes before settling
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_ctl_reg <= CORE_CTL_RESET;
      supply_ctl_reg <= SUPPLY_CTL_RESET;
      core_cnt_reg <= MASK_CNT_W'(SLOW_MASK_CYCLES);
      supply_cnt_reg <= MASK_CNT_W'(SLOW_MASK_CYCLES);
      core_dly_reg <= 1'b1;
      supply_dly_reg <= 1'b1;
    end
    else
    begin
      core_ctl_reg <= core_ctl_next;
      supply_ctl_reg <= supply_ctl_next;
      core_cnt_reg <= core_cnt_next;
      supply_cnt_reg <= supply_cnt_next;
      core_dly_reg <= core_dly_next;
      supply_dly_reg <= supply_dly_next;
    end
  end

  // ------------------------------------------------------------
  // unit state mapping and wake-up path
  // ------------------------------------------------------------
  logic in_lpm; // low-power mode 2, 3 or 4 requested
  logic core_supervisor_enable, core_supervisor_lowpower_keep, core_supervisor_fullperf;
  logic core_monitor_enable, core_monitor_fullperf, core_side_auto_control;
  logic supply_supervisor_enable, supply_supervisor_lowpower_keep, supply_supervisor_fullperf;
  logic supply_monitor_enable, supply_monitor_fullperf, supply_side_auto_control;
  logic overvoltage_protect_enable;
  ssmc_unit_state_t cs_am, cm_am, ss_am, sm_am; // active-mode states
  ssmc_unit_state_t cs_st, cm_st, ss_st, sm_st; // effective states
  logic [1:0] cs_reg, cm_reg, ss_reg, sm_reg; // registered unit states
  logic slow_wake_reg, slow_wake_next; // registered wake path
  logic [1:0] cs_next, cm_next, ss_next, sm_next;

  assign in_lpm = (power_mode >= PM_LPM2) && (power_mode <= PM_LPM4);
  assign core_supervisor_enable = core_ctl_reg[SUP_EN_BIT];
  assign core_supervisor_lowpower_keep = core_ctl_reg[SUP_KEEP_BIT];
  assign core_supervisor_fullperf = core_ctl_reg[SUP_FP_BIT];
  assign core_monitor_enable = core_ctl_reg[MON_EN_BIT];
  assign core_monitor_fullperf = core_ctl_reg[MON_FP_BIT];
  assign core_side_auto_control = core_ctl_reg[AUTO_BIT];
  assign supply_supervisor_enable = supply_ctl_reg[SUP_EN_BIT];
  assign supply_supervisor_lowpower_keep = supply_ctl_reg[SUP_KEEP_BIT];
  assign supply_supervisor_fullperf = supply_ctl_reg[SUP_FP_BIT];
  assign supply_monitor_enable = supply_ctl_reg[MON_EN_BIT];
  assign supply_monitor_fullperf = supply_ctl_reg[MON_FP_BIT];
  assign supply_side_auto_control = supply_ctl_reg[AUTO_BIT];
  assign overvoltage_protect_enable = supply_ctl_reg[OVP_EN_BIT];

  // the monitor has no keep bit: manual control keeps it on in LPM
  always_comb
  begin
    cs_am = active_state(core_supervisor_enable, core_supervisor_fullperf);
    cm_am = active_state(core_monitor_enable, core_monitor_fullperf);
    ss_am = active_state(supply_supervisor_enable, supply_supervisor_fullperf);
    sm_am = active_state(supply_monitor_enable, supply_monitor_fullperf);
    cs_st = cs_am;
    cm_st = cm_am;
    ss_st = ss_am;
    sm_st = sm_am;
    if (in_lpm)
    begin
      cs_st = lpm_state(cs_am, core_supervisor_lowpower_keep, core_side_auto_control);
      cm_st = lpm_state(cm_am, 1'b1, core_side_auto_control);
      ss_st = lpm_state(ss_am, supply_supervisor_lowpower_keep, supply_side_auto_control);
      sm_st = lpm_state(sm_am, 1'b1, supply_side_auto_control);
      // automatic supply control idles the monitor completely
      if (supply_side_auto_control)
        sm_st = SSMC_OFF;
    end
    cs_next = cs_st;
    cm_next = cm_st;
    ss_next = ss_st;
    sm_next = sm_st;
    // any core unit enabled in normal performance forces slow wake
    slow_wake_next = (cs_am == SSMC_NORMAL) || (cm_am == SSMC_NORMAL);
  end

  // registered so the analog side sees glitch-free states
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_reg <= 2'b00;
      cm_reg <= 2'b00;
      ss_reg <= 2'b00;
      sm_reg <= 2'b00;
      slow_wake_reg <= 1'b0;
    end
    else
    begin
      cs_reg <= cs_next;
      cm_reg <= cm_next;
      ss_reg <= ss_next;
      sm_reg <= sm_next;
      slow_wake_reg <= slow_wake_next;
    end
  end

  assign core_supervisor_state = cs_reg;
  assign core_monitor_state = cm_reg;
  assign supply_supervisor_state = ss_reg;
  assign supply_monitor_state = sm_reg;
  assign slow_wake = slow_wake_reg;

  // ------------------------------------------------------------
  // event routing
  // ------------------------------------------------------------
  logic por_reg, por_next; // power-on reset request
  logic irq_reg, irq_next; // interrupt request
  logic cs_ev, cm_ev, ss_ev, sm_ev; // qualified events

  // events count only from running units after their mask has expired
  always_comb
  begin
    cs_ev = core_supervisor_trip && (cs_reg != 2'b00) && !core_dly_reg;
    cm_ev = core_monitor_trip && (cm_reg != 2'b00) && !core_dly_reg;
    ss_ev = supply_supervisor_trip && (ss_reg != 2'b00) && !supply_dly_reg;
    sm_ev = supply_monitor_trip && (sm_reg != 2'b00) && !supply_dly_reg;
    por_next = 1'b0;
    irq_next = 1'b0;
    // core events go to reset or interrupt per their enable bit
    if (cs_ev)
    begin
      if (core_ctl_reg[SUP_RST_EN_BIT])
        por_next = 1'b1;
      else
        irq_next = 1'b1;
    end
    if (cm_ev)
    begin
      if (core_ctl_reg[MON_RST_EN_BIT])
        por_next = 1'b1;
      else
        irq_next = 1'b1;
    end
    if (ss_ev)
    begin
      if (supply_ctl_reg[SUP_RST_EN_BIT])
        por_next = 1'b1;
      else
        irq_next = 1'b1;
    end
    // overvoltage mode: monitor trip always requests power-on reset
    if (sm_ev)
    begin
      if (overvoltage_protect_enable || supply_ctl_reg[MON_RST_EN_BIT])
        por_next = 1'b1;
      else
        irq_next = 1'b1;
    end
  end

  // one-cycle pulses per qualified event cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      por_reg <= por_next;
      irq_reg <= irq_next;
    end
  end

  assign power_on_reset_req = por_reg;
  assign supervisor_irq = irq_reg;

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  logic [15:0] rdata_reg, rdata_next; // read data, valid the cycle after the strobe

  // software polls the flags before low-power entry; unmapped reads give zero
  always_comb
  begin
    rdata_next = 16'h0000;
    if (reg_read)
    begin
      unique case (reg_addr)
        CORE_CTL_ADDR: rdata_next = core_ctl_reg;
        SUPPLY_CTL_ADDR: rdata_next = supply_ctl_reg;
        FLAG_ADDR: rdata_next = {13'h0000, slow_wake_reg, supply_dly_reg, core_dly_reg};
        STATE_ADDR: rdata_next = {8'h00, sm_reg, ss_reg, cm_reg, cs_reg};
        POWER_MODE_ADDR: rdata_next = {13'h0000, power_mode};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

endmodule : ssmc_top

`default_nettype wire

//--- src/ssmc_pkg.sv
package ssmc_pkg;

  // ------------------------------------------------------------
  // register offsets (word index on the plain register port)
  // ------------------------------------------------------------
  localparam logic [3:0] CORE_CTL_ADDR = 4'h0;
  localparam logic [3:0] SUPPLY_CTL_ADDR = 4'h1;
  localparam logic [3:0] FLAG_ADDR = 4'h2;
  localparam logic [3:0] STATE_ADDR = 4'h3;
  localparam logic [3:0] POWER_MODE_ADDR = 4'h4;

  // ------------------------------------------------------------
  // control register field positions
  // ------------------------------------------------------------
  localparam int SUP_EN_BIT = 0;
  localparam int SUP_KEEP_BIT = 1;
  localparam int SUP_FP_BIT = 2;
  localparam int MON_EN_BIT = 3;
  localparam int MON_FP_BIT = 4;
  localparam int AUTO_BIT = 5;
  localparam int SUP_RST_EN_BIT = 6;
  localparam int MON_RST_EN_BIT = 7;
  localparam int OVP_EN_BIT = 8;

  // flag register field positions
  localparam int CORE_DLY_BIT = 0;
  localparam int SUPPLY_DLY_BIT = 1;
  localparam int SLOW_WAKE_BIT = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CORE_CTL_RESET = 16'h00C9;
  localparam logic [15:0] SUPPLY_CTL_RESET = 16'h0049;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLOCK_MHZ = 10;
  localparam int FAST_MASK_US = 2;
  localparam int SLOW_MASK_US = 150;
  localparam int FAST_MASK_CYCLES = FAST_MASK_US * CLOCK_MHZ;
  localparam int SLOW_MASK_CYCLES = SLOW_MASK_US * CLOCK_MHZ;
  localparam int MASK_CNT_W = 11;

  // ------------------------------------------------------------
  // unit operating states and power modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SSMC_OFF,
    SSMC_NORMAL,
    SSMC_FULL
  } ssmc_unit_state_t;

  // 0 active, 1 and 2 light sleep, 3..5 deep sleep (units may switch off)
  localparam logic [2:0] PM_LPM2 = 3'h3;
  localparam logic [2:0] PM_LPM4 = 3'h5;

endpackage : ssmc_pkg

//--- bench/ssmc_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module ssmc_top_props
  import ssmc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // mode and comparator events
  input wire logic [2:0] power_mode,
  input wire logic core_supervisor_trip,
  input wire logic core_monitor_trip,
  input wire logic supply_supervisor_trip,
  input wire logic supply_monitor_trip,
  // unit states and results
  input wire logic [1:0] core_supervisor_state,
  input wire logic [1:0] core_monitor_state,
  input wire logic [1:0] supply_supervisor_state,
  input wire logic [1:0] supply_monitor_state,
  input wire logic slow_wake,
  input wire logic power_on_reset_req,
  input wire logic supervisor_irq
);
  // shadow control words and mask counters
  logic [15:0] core_reg, core_next, supply_reg, supply_next;
  logic [10:0] cdly_reg, cdly_next, sdly_reg, sdly_next;
  // edges since release; masks only run once the synchroniser lets go
  logic [2:0] up_reg, up_next;
  logic ready, lpm, cs_hit, cm_hit, ss_hit, sm_hit, por_src, irq_src;
  logic [1:0] cs_exp, ss_exp, sm_exp;

  // state of one unit in the present power mode
  function automatic logic [1:0] unit_state(input logic en, fp, keep, auto_c, low);
    if (!en)
      return 2'h0;
    if (!low)
      return fp ? 2'h2 : 2'h1;
    if (auto_c)
      return fp ? 2'h1 : 2'h0;
    return keep ? (fp ? 2'h2 : 2'h1) : 2'h0;
  endfunction : unit_state

  // next shadow values; a write restarts that side's mask
  always_comb
  begin
    core_next = core_reg;
    supply_next = supply_reg;
    up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
    cdly_next = (cdly_reg != 11'h0 && up_reg >= 3'h2) ? cdly_reg - 11'h1 : cdly_reg;
    sdly_next = (sdly_reg != 11'h0 && up_reg >= 3'h2) ? sdly_reg - 11'h1 : sdly_reg;
    if (reg_write && reg_addr == CORE_CTL_ADDR)
    begin
      core_next = reg_wdata;
      cdly_next = reg_wdata[SUP_FP_BIT] ? 11'(FAST_MASK_CYCLES) : 11'(SLOW_MASK_CYCLES);
    end
    if (reg_write && reg_addr == SUPPLY_CTL_ADDR)
    begin
      supply_next = reg_wdata;
      sdly_next = reg_wdata[SUP_FP_BIT] ? 11'(FAST_MASK_CYCLES) : 11'(SLOW_MASK_CYCLES);
    end
  end

  // shadow registers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_reg <= CORE_CTL_RESET;
      supply_reg <= SUPPLY_CTL_RESET;
      cdly_reg <= 11'(SLOW_MASK_CYCLES);
      sdly_reg <= 11'(SLOW_MASK_CYCLES);
      up_reg <= 3'h0;
    end
    else
    begin
      core_reg <= core_next;
      supply_reg <= supply_next;
      cdly_reg <= cdly_next;
      sdly_reg <= sdly_next;
      up_reg <= up_next;
    end
  end

  assign ready = up_reg >= 3'h4;
  assign lpm = (power_mode >= PM_LPM2) && (power_mode <= PM_LPM4);
  assign cs_exp = unit_state(core_reg[0], core_reg[2], core_reg[1], core_reg[5], lpm);
  assign ss_exp = unit_state(supply_reg[0], supply_reg[2], supply_reg[1], supply_reg[5], lpm);
  // auto control idles the supply monitor in low power
  assign sm_exp = (supply_reg[5] && lpm) ? 2'h0 : unit_state(supply_reg[3], supply_reg[4], 1'b1, supply_reg[5], lpm);
  // a trip counts only from a running unit whose mask has run out
  assign cs_hit = core_supervisor_trip && core_supervisor_state != 2'h0 && cdly_reg == 11'h0;
  assign cm_hit = core_monitor_trip && core_monitor_state != 2'h0 && cdly_reg == 11'h0;
  assign ss_hit = supply_supervisor_trip && supply_supervisor_state != 2'h0 && sdly_reg == 11'h0;
  assign sm_hit = supply_monitor_trip && supply_monitor_state != 2'h0 && sdly_reg == 11'h0;
  assign por_src = (cs_hit && core_reg[6]) || (cm_hit && core_reg[7]) || (ss_hit && supply_reg[6])
    || (sm_hit && (supply_reg[8] || supply_reg[7]));
  assign irq_src = (cs_hit && !core_reg[6]) || (cm_hit && !core_reg[7]) || (ss_hit && !supply_reg[6])
    || (sm_hit && !supply_reg[8] && !supply_reg[7]);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  delay_flag_a: assert property (
    ready && reg_read && reg_addr == FLAG_ADDR |=> reg_rdata[1:0] == {$past(sdly_reg != 11'h0), $past(cdly_reg != 11'h0)})
    else $error("delay flag read mismatch");
  core_sup_state_a: assert property (ready |-> core_supervisor_state == $past(cs_exp))
    else $error("core supervisor state mismatch");
  supply_sup_state_a: assert property (ready |-> supply_supervisor_state == $past(ss_exp))
    else $error("supply supervisor state mismatch");
  supply_mon_state_a: assert property (ready |-> supply_monitor_state == $past(sm_exp))
    else $error("supply monitor state mismatch");
  wake_path_a: assert property (
    ready |-> slow_wake == $past((core_reg[0] && !core_reg[2]) || (core_reg[3] && !core_reg[4])))
    else $error("wake path mismatch");
  reset_route_a: assert property (ready && por_src |=> power_on_reset_req)
    else $error("reset event lost");
  irq_route_a: assert property (ready && irq_src |=> supervisor_irq)
    else $error("interrupt event lost");
  reset_cause_a: assert property (power_on_reset_req |-> $past(por_src))
    else $error("reset without cause");
  irq_cause_a: assert property (supervisor_irq |-> $past(irq_src))
    else $error("interrupt without cause");
endmodule : ssmc_top_props

bind ssmc_top ssmc_top_props i_props (
  .clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .power_mode,
  .core_supervisor_trip, .core_monitor_trip, .supply_supervisor_trip, .supply_monitor_trip,
  .core_supervisor_state, .core_monitor_state, .supply_supervisor_state, .supply_monitor_state,
  .slow_wake, .power_on_reset_req, .supervisor_irq
);
`default_nettype wire

//--- bench/ssmc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ssmc_top_tb
  import ssmc_pkg::*;
;
  // ------------------------------------------------------------
  // signals and scenario tables
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic arst_n, reg_write, reg_read, slow_wake, por, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [2:0] power_mode;
  logic [3:0] trip; // supply mon, supply sup, core mon, core sup
  logic [7:0] st;
  int checks = 0;
  int n_mismatch = 0;
  // control word pairs and power modes for the state map
  logic [15:0] cfg_c [7] = '{16'h0009, 16'h001f, 16'h003f, 16'h0029, 16'h0003, 16'h0000, 16'h0018};
  logic [15:0] cfg_s [7] = '{16'h0009, 16'h001f, 16'h003f, 16'h0029, 16'h0105, 16'h0018, 16'h0000};
  logic [2:0] pms [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
  // event rows: control words, trip, expected {reset, irq}
  // supervisor full-performance bit set everywhere so each mask is the short one
  logic [15:0] ev_c [9] = '{16'h0045, 16'h0005, 16'h009C, 16'h001C, 16'h0004, 16'h0004, 16'h0004, 16'h0045, 16'h0004};
  logic [15:0] ev_s [9] = '{16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0045, 16'h011C, 16'h001C, 16'h0004, 16'h0004};
  logic [3:0] ev_t [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h8, 4'h8, 4'h1, 4'h1};
  logic [1:0] ev_e [9] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0};

  ssmc_top i_dut (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .power_mode(power_mode),
    .core_supervisor_trip(trip[0]), .core_monitor_trip(trip[1]), .supply_supervisor_trip(trip[2]),
    .supply_monitor_trip(trip[3]), .core_supervisor_state(st[1:0]), .core_monitor_state(st[3:2]),
    .supply_supervisor_state(st[5:4]), .supply_monitor_state(st[7:6]), .slow_wake(slow_wake),
    .power_on_reset_req(por), .supervisor_irq(irq)
  );

  // 100 ns period
  always #50 clock = ~clock;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] ust(input logic en, fp, keep, auto_c, low);
    if (!en)
      return 2'h0;
    if (!low)
      return fp ? 2'h2 : 2'h1;
    if (auto_c)
      return fp ? 2'h1 : 2'h0;
    return keep ? (fp ? 2'h2 : 2'h1) : 2'h0;
  endfunction : ust

  // packed states {sm, ss, cm, cs}; monitors have no keep bit
  function automatic logic [7:0] st_exp(input logic [15:0] c, s, input logic low);
    st_exp = {(s[5] && low) ? 2'h0 : ust(s[3], s[4], 1'b1, s[5], low), ust(s[0], s[2], s[1], s[5], low),
      ust(c[3], c[4], 1'b1, c[5], low), ust(c[0], c[2], c[1], c[5], low)};
  endfunction : st_exp

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // software side: poll both delay flags clear before any deep sleep request
  task automatic wait_settled;
    logic [15:0] f;
    int n;
    n = 0;
    rd(FLAG_ADDR, f);
    while ((f[1:0] != 2'b00) && (n < 2000))
    begin
      rd(FLAG_ADDR, f);
      n++;
    end
    chk("settle wait", {15'h0000, n >= 2000}, 16'h0000);
    if (n >= 2000)
      report_and_stop();
  endtask : wait_settled

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    power_mode = 3'h0;
    trip = 4'h0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(CORE_CTL_ADDR, d);
    chk("core ctl", d, CORE_CTL_RESET);
    rd(SUPPLY_CTL_ADDR, d);
    chk("supply ctl", d, SUPPLY_CTL_RESET);
    rd(STATE_ADDR, d);
    chk("reset states", d, {8'h00, st_exp(CORE_CTL_RESET, SUPPLY_CTL_RESET, 1'b0)});
    rd(FLAG_ADDR, d);
    chk("reset flags", d, 16'h0007);
    rd(4'h9, d);
    chk("unmapped read", d, 16'h0000);
    $display("test reset values done");
    // let the mask armed by reset run out first
    repeat (1600) @(posedge clock);
    for (int i = 0; i < 4; i++)
    begin
      wr((i < 2) ? CORE_CTL_ADDR : SUPPLY_CTL_ADDR, i[0] ? 16'h0000 : 16'h0005);
      rd(FLAG_ADDR, d);
      chk("flag after write", d & 16'h0003, (i < 2) ? 16'h0001 : 16'h0002);
      repeat ((i[0] ? SLOW_MASK_CYCLES : FAST_MASK_CYCLES) - 6) @(posedge clock);
      rd(FLAG_ADDR, d);
      chk("flag before expiry", d & 16'h0003, (i < 2) ? 16'h0001 : 16'h0002);
      repeat (4) @(posedge clock);
      rd(FLAG_ADDR, d);
      chk("flag after expiry", d & 16'h0003, 16'h0000);
    end
    wr(FLAG_ADDR, 16'hffff);
    rd(FLAG_ADDR, d);
    chk("flag write ignored", d & 16'h0003, 16'h0000);
    $display("test settling masks done");
    for (int i = 0; i < 7; i++)
    begin
      wr(CORE_CTL_ADDR, cfg_c[i]);
      wr(SUPPLY_CTL_ADDR, cfg_s[i]);
      wait_settled();
      for (int j = 0; j < 4; j++)
      begin
        @(posedge clock);
        power_mode <= pms[j];
        repeat (2) @(posedge clock);
        rd(STATE_ADDR, d);
        chk("unit states", d, {8'h00, st_exp(cfg_c[i], cfg_s[i], pms[j] >= PM_LPM2)});
        chk("slow wake", {15'h0000, slow_wake},
          {15'h0000, (cfg_c[i][0] && !cfg_c[i][2]) || (cfg_c[i][3] && !cfg_c[i][4])});
        rd(POWER_MODE_ADDR, d);
        chk("power mode", d, {13'h0000, pms[j]});
      end
      // back to active before the next control write
      @(posedge clock);
      power_mode <= 3'h0;
    end
    $display("test unit states done");
    // row 7 trips inside the fresh mask and must be swallowed
    for (int i = 0; i < 9; i++)
    begin
      wr(CORE_CTL_ADDR, ev_c[i]);
      wr(SUPPLY_CTL_ADDR, ev_s[i]);
      power_mode <= 3'h0;
      repeat ((i == 7) ? 2 : 30) @(posedge clock);
      trip <= ev_t[i];
      @(posedge clock);
      trip <= 4'h0;
      #1;
      chk("event routing", {14'h0000, por, irq}, {14'h0000, ev_e[i]});
    end
    $display("test event routing done");
    report_and_stop();
  end

  // hang guard
  initial
  begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    $display("FAIL watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule : ssmc_top_tb
`default_nettype wire
